// file: verilog/taxe_exec.sv
/*
 * Execution unit for table read, table write, test and skip on zero,
 * and xor of the accumulator with an immediate byte.
 * Assumes program memory and file registers answer in the same cycle as a
 * registered read strobe, and that the fetch stage holds its word while
 * busy_o is high.
 */
`timescale 1ns/1ps

// Overview of operation
// - Table read decoded, two bits pick pointer mode
// - Post modes fetch then adjust; pre increments first
// - Pointer is full 21-bit byte address
// - Pointer bit zero picks low or high byte
// - Table write fills one of eight holding registers
// - Post-increment write uses old pointer, then advances
// - Pre-increment write advances first, then stores
// - Zero operand discards next instruction, two cycles
// - Skipping a two-word instruction takes three cycles
// - Bank bit picks access bank or bank select
// - Extended set indexes offsets up to 95
// - Xor immediate into accumulator, sets negative, zero
// - Extended set off until its enable is set
module taxe_exec
    import taxe_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    // Instruction stream
    input  wire logic              instr_valid_i,
    input  wire logic [15:0]       instr_i,
    input  wire logic              two_word_i,
    output logic                   busy_o,
    output logic                   skip_o,
    // Program memory read
    output taxe_prog_req_t         prog_req_o,
    input  wire logic [15:0]       prog_data_i,
    // File register read
    output taxe_file_req_t         file_req_o,
    input  wire logic [7:0]        file_data_i,
    // Holding register read for the programming logic
    input  wire logic [HIDX_W-1:0] hold_idx_i,
    output logic [7:0]             hold_data_o,
    // Software register port
    input  wire logic [2:0]        reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic [31:0]            reg_rdata_o
);

    // ==========================================================
    // State
    // ==========================================================
    taxe_state_t       state_r;                         // Sequencer state
    logic [PTR_W-1:0]  table_pointer_r;                 // Byte pointer
    logic [7:0]        table_latch_r;                   // Data latch
    logic [7:0]        acc_r;                           // Accumulator
    logic              neg_r;                           // Negative flag
    logic              zero_r;                          // Zero flag
    logic              extended_set_enable_r;           // Extended set switch
    logic [3:0]        bank_select_reg_r;               // Bank select
    logic [FADR_W-1:0] index_base_r;                    // Literal offset base
    taxe_hold_wr_t     hold_wr_r;                       // Holding write request

    // ==========================================================
    // Decode
    // ==========================================================
    logic              squash;                          // Current slot is discarded
    logic              accept;                          // Instruction taken this cycle
    logic              is_rd, is_wt, is_tst, is_xor;    // Decoded operations
    logic [1:0]        mode;                            // Pointer mode field
    logic [PTR_W-1:0]  ptr_inc, ptr_dec;                // Neighbouring pointers
    logic [PTR_W-1:0]  op_addr;                         // Address used by the access
    logic [PTR_W-1:0]  ptr_after;                       // Pointer after the instruction
    logic [7:0]        f_op;                            // File operand
    logic              bank_bit;                        // Bank operand bit
    logic [FADR_W-1:0] file_addr;                       // Resolved file address
    logic [7:0]        xor_res;                         // Xor result
    logic              sw_wr_ptr;                       // Software pointer write

    // Zero in the evaluation cycle drops the fetched word, skip2 its tail
    assign squash  = ((state_r == ST_TST_EVAL) && (file_data_i == 8'h00))
                     || (state_r == ST_SKIP2);
    assign accept  = instr_valid_i && !busy_o && !squash;
    assign mode    = instr_i[1:0];
    assign is_rd   = accept && (instr_i[15:2] == OPC_TREAD);
    assign is_wt   = accept && (instr_i[15:2] == OPC_TWRITE);
    assign is_tst  = accept && (instr_i[15:9] == OPC_TSTZ);
    assign is_xor  = accept && (instr_i[15:8] == OPC_XORK);
    assign ptr_inc = table_pointer_r + 21'h000001;
    assign ptr_dec = table_pointer_r - 21'h000001;
    assign f_op     = instr_i[7:0];
    assign bank_bit = instr_i[8];
    assign xor_res  = acc_r ^ instr_i[7:0];
    assign sw_wr_ptr = reg_wr_i && (reg_addr_i == OFS_PTR);

    // Access address and final pointer per mode
    always_comb begin
        op_addr   = table_pointer_r;
        ptr_after = table_pointer_r;
        unique case (mode)
            MODE_KEEP: ptr_after = table_pointer_r;
            MODE_PINC: ptr_after = ptr_inc;
            MODE_PDEC: ptr_after = ptr_dec;
            MODE_PRE: begin
                op_addr   = ptr_inc;
                ptr_after = ptr_inc;
            end
        endcase
    end

    // File address: bank select, indexed offset or access bank
    always_comb begin
        if (bank_bit) begin
            file_addr = {bank_select_reg_r, f_op};
        end else if (extended_set_enable_r && (f_op <= INDEX_LAST)) begin
            file_addr = index_base_r + {4'h0, f_op};
        end else if (f_op < ACCESS_SPLIT) begin
            file_addr = {BANK_LOW, f_op};
        end else begin
            file_addr = {BANK_HIGH, f_op};
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Table operations hold the fetch for one extra cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
            busy_o  <= 1'b0;
        end else begin
            busy_o <= is_rd || is_wt;
            if (is_rd) begin
                state_r <= ST_RD_WAIT;
            end else if (is_wt) begin
                state_r <= ST_WT_DONE;
            end else if (is_tst) begin
                state_r <= ST_TST_EVAL;
            end else if ((state_r == ST_TST_EVAL) && squash && two_word_i) begin
                state_r <= ST_SKIP2;
            end else begin
                state_r <= ST_IDLE;
            end
        end
    end

    // Skip report, one cycle per discarded slot
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            skip_o <= 1'b0;
        end else begin
            skip_o <= squash;
        end
    end

    // ==========================================================
    // Table pointer and latch
    // ==========================================================
    // Instruction update wins over a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            table_pointer_r <= RST_PTR;
        end else if (is_rd || is_wt) begin
            table_pointer_r <= ptr_after;
        end else if (sw_wr_ptr) begin
            table_pointer_r <= reg_wdata_i[PTR_W-1:0];
        end
    end

    // Byte picked by address bit zero when the word returns
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            table_latch_r <= RST_BYTE;
        end else if (state_r == ST_RD_WAIT) begin
            table_latch_r <= prog_req_o.addr[0] ? prog_data_i[15:8]
                                                : prog_data_i[7:0];
        end else if (reg_wr_i && (reg_addr_i == OFS_LATCH)) begin
            table_latch_r <= reg_wdata_i[7:0];
        end
    end

    // Program memory request, address held after the strobe
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prog_req_o <= '0;
        end else begin
            prog_req_o.rd <= is_rd;
            if (is_rd) begin
                prog_req_o.addr <= op_addr;
            end
        end
    end

    // Holding write request; latch itself is left alone
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hold_wr_r <= '0;
        end else begin
            hold_wr_r.we <= is_wt;
            if (is_wt) begin
                hold_wr_r.idx  <= op_addr[HIDX_W-1:0];
                hold_wr_r.data <= table_latch_r;
            end
        end
    end

    taxe_hold_mem u_hold (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .wr_i      (hold_wr_r),
        .rd_idx_i  (hold_idx_i),
        .rd_data_o (hold_data_o)
    );

    // ==========================================================
    // File read for test and skip
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            file_req_o <= '0;
        end else begin
            file_req_o.rd <= is_tst;
            if (is_tst) begin
                file_req_o.addr <= file_addr;
            end
        end
    end

    // ==========================================================
    // Accumulator and flags
    // ==========================================================
    // Only the xor touches flags; table and test leave them alone
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc_r  <= RST_BYTE;
            neg_r  <= 1'b0;
            zero_r <= 1'b0;
        end else if (is_xor) begin
            acc_r  <= xor_res;
            neg_r  <= xor_res[7];
            zero_r <= (xor_res == 8'h00);
        end else if (reg_wr_i && (reg_addr_i == OFS_ACC)) begin
            acc_r <= reg_wdata_i[7:0];
        end
    end

    // ==========================================================
    // Configuration registers
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            extended_set_enable_r <= RST_EXT;
            bank_select_reg_r     <= RST_BANK;
            index_base_r          <= RST_INDEX;
        end else if (reg_wr_i && (reg_addr_i == OFS_CTRL)) begin
            extended_set_enable_r <= reg_wdata_i[CTRL_EXT_BIT];
            bank_select_reg_r     <= reg_wdata_i[CTRL_BANK_MSB:CTRL_BANK_LSB];
        end else if (reg_wr_i && (reg_addr_i == OFS_INDEX)) begin
            index_base_r <= reg_wdata_i[FADR_W-1:0];
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFS_PTR:    reg_rdata_o <= {11'h000, table_pointer_r};
                OFS_LATCH:  reg_rdata_o <= {24'h000000, table_latch_r};
                OFS_ACC:    reg_rdata_o <= {24'h000000, acc_r};
                OFS_STATUS: reg_rdata_o <= {29'h00000000, busy_o, neg_r, zero_r};
                OFS_CTRL:   reg_rdata_o <= {24'h000000, bank_select_reg_r, 3'h0, extended_set_enable_r};
                OFS_INDEX:  reg_rdata_o <= {20'h00000, index_base_r};
                default:    reg_rdata_o <= 32'h00000000;                  // Unmapped
            endcase
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_tbl_two_cycle: assert property ((is_rd || is_wt) |=> busy_o ##1 !busy_o)
        else $error("table op did not take two cycles");
    a_rd_post_ptr: assert property ((is_rd && mode == MODE_PINC) |=>
        (table_pointer_r == $past(ptr_inc)) && (prog_req_o.addr == $past(table_pointer_r)))
        else $error("post-increment read order wrong");
    a_rd_pre_addr: assert property ((is_rd && mode == MODE_PRE) |=>
        prog_req_o.addr == $past(table_pointer_r) + 21'h000001)
        else $error("pre-increment read address wrong");
    a_byte_pick: assert property ((state_r == ST_RD_WAIT) |=>
        table_latch_r == ($past(prog_req_o.addr[0]) ? $past(prog_data_i[15:8]) : $past(prog_data_i[7:0])))
        else $error("wrong byte latched");
    a_wt_post_inc: assert property ((is_wt && mode == MODE_PINC) |=>
        hold_wr_r.we && hold_wr_r.idx == $past(table_pointer_r[2:0])
        && table_pointer_r == $past(ptr_inc) && table_latch_r == $past(table_latch_r))
        else $error("post-increment write wrong");
    a_wt_pre_inc: assert property ((is_wt && mode == MODE_PRE) |=>
        hold_wr_r.idx == $past(ptr_inc[2:0]) && hold_wr_r.data == $past(table_latch_r))
        else $error("pre-increment write wrong");
    a_wt_post_dec: assert property ((is_wt && mode == MODE_PDEC) |=>
        hold_wr_r.idx == $past(table_pointer_r[2:0]) && table_pointer_r == $past(ptr_dec))
        else $error("post-decrement write wrong");
    a_skip_zero: assert property ((is_tst ##1 file_data_i == 8'h00) |->
        !accept ##1 skip_o)
        else $error("zero test did not skip");
    a_skip_two: assert property ((is_tst ##1 (file_data_i == 8'h00 && two_word_i)) |=>
        state_r == ST_SKIP2 ##1 skip_o)
        else $error("two-word skip not three cycles");
    a_bank_addr: assert property ((is_tst && bank_bit) |=>
        file_req_o.addr == {$past(bank_select_reg_r), $past(f_op)})
        else $error("bank select address wrong");
    a_index_off: assert property ((is_tst && !bank_bit && !extended_set_enable_r && f_op <= INDEX_LAST) |=>
        file_req_o.addr[11:8] == BANK_LOW)
        else $error("indexed mode active while disabled");
    a_ext_reset: assert property ($fell(reset_i) |-> !extended_set_enable_r)
        else $error("extended set not off after reset");
    a_xor_flags: assert property (is_xor |=> acc_r == ($past(acc_r) ^ $past(instr_i[7:0]))
        && zero_r == (acc_r == 8'h00) && neg_r == acc_r[7])
        else $error("xor result or flags wrong");

    c_table_read:  cover property (is_rd ##2 instr_valid_i);
    c_table_write: cover property (is_wt && mode == MODE_PRE);
    c_skip_two:    cover property (state_r == ST_SKIP2);
    c_xor_zero:    cover property (is_xor && xor_res == 8'h00);

endmodule

// file: verilog/taxe_pkg.sv
/*
 * Package of the table access and test execution block: register map,
 * field positions, reset values, opcode patterns and carrier structs.
 * Assumes a single 125 MHz clock domain and a plain register port.
 */
package taxe_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int PTR_W  = 21;                         // Table pointer width, 2 Mbyte space
    localparam int FADR_W = 12;                         // Full file register address
    localparam int HOLD_N = 8;                          // Number of holding registers
    localparam int HIDX_W = 3;                          // Holding register index width

    // ==========================================================
    // Register offsets (software port)
    // ==========================================================
    localparam logic [2:0] OFS_PTR    = 3'h0;           // Table pointer
    localparam logic [2:0] OFS_LATCH  = 3'h1;           // Table latch
    localparam logic [2:0] OFS_ACC    = 3'h2;           // Accumulator
    localparam logic [2:0] OFS_STATUS = 3'h3;           // Flags and state, read only
    localparam logic [2:0] OFS_CTRL   = 3'h4;           // Extended enable and bank select
    localparam logic [2:0] OFS_INDEX  = 3'h5;           // Index base for literal offsets

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int STS_Z_BIT    = 0;                    // Zero flag
    localparam int STS_N_BIT    = 1;                    // Negative flag
    localparam int STS_BUSY_BIT = 2;                    // Second cycle in progress
    localparam int CTRL_EXT_BIT = 0;                    // Extended set enable
    localparam int CTRL_BANK_LSB = 4;                   // Bank select low bit
    localparam int CTRL_BANK_MSB = 7;                   // Bank select high bit

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [PTR_W-1:0]  RST_PTR   = 21'h000000;
    localparam logic [7:0]        RST_BYTE  = 8'h00;
    localparam logic [7:0]        RST_HOLD  = 8'hff;    // Erased state
    localparam logic [3:0]        RST_BANK  = 4'h0;
    localparam logic              RST_EXT   = 1'b0;     // Extended set off by default
    localparam logic [FADR_W-1:0] RST_INDEX = 12'h000;

    // ==========================================================
    // Opcode patterns and operand fields
    // ==========================================================
    localparam logic [13:0] OPC_TREAD  = 14'h0002;      // Upper 14 bits of table read
    localparam logic [13:0] OPC_TWRITE = 14'h0003;      // Upper 14 bits of table write
    localparam logic [6:0]  OPC_TSTZ  = 7'h33;          // Upper 7 bits of test and skip
    localparam logic [7:0]  OPC_XORK  = 8'h0a;          // Upper 8 bits of xor immediate
    localparam logic [1:0]  MODE_KEEP = 2'h0;           // Pointer unchanged
    localparam logic [1:0]  MODE_PINC = 2'h1;           // Post-increment
    localparam logic [1:0]  MODE_PDEC = 2'h2;           // Post-decrement
    localparam logic [1:0]  MODE_PRE  = 2'h3;           // Pre-increment
    localparam logic [7:0]  ACCESS_SPLIT = 8'h60;       // First upper access-bank address
    localparam logic [7:0]  INDEX_LAST   = 8'h5f;       // Last indexed offset, 95
    localparam logic [3:0]  BANK_LOW     = 4'h0;
    localparam logic [3:0]  BANK_HIGH    = 4'hf;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic             rd;                           // One cycle read strobe
        logic [PTR_W-1:0] addr;                         // Byte address, bit 0 selects byte
    } taxe_prog_req_t;

    typedef struct packed {
        logic              we;                          // Write strobe
        logic [HIDX_W-1:0] idx;                         // Holding register index
        logic [7:0]        data;                        // Byte written
    } taxe_hold_wr_t;

    typedef struct packed {
        logic              rd;                          // File read strobe
        logic [FADR_W-1:0] addr;                        // Resolved file address
    } taxe_file_req_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RD_WAIT, ST_WT_DONE, ST_TST_EVAL, ST_SKIP2
    } taxe_state_t;

endpackage

// file: verilog/taxe_hold_mem.sv
/*
 * Eight byte holding register file filled by table writes.
 * Assumes the programming logic reads it through the registered port
 * and commits it to program memory on its own schedule.
 */
`timescale 1ns/1ps

module taxe_hold_mem
    import taxe_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    // Write port
    input  wire taxe_hold_wr_t     wr_i,
    // Registered read port
    input  wire logic [HIDX_W-1:0] rd_idx_i,
    output logic [7:0]             rd_data_o
);

    logic [7:0] mem_r [HOLD_N];                         // Storage

    // ==========================================================
    // Storage write, reset to the erased value
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < HOLD_N; i++) begin
                mem_r[i] <= RST_HOLD;
            end
        end else if (wr_i.we) begin
            mem_r[wr_i.idx] <= wr_i.data;
        end
    end

    // ==========================================================
    // Read data from a register
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_data_o <= RST_HOLD;
        end else begin
            rd_data_o <= mem_r[rd_idx_i];
        end
    end

endmodule

// file: verif/taxe_pmem_model.sv
/* Program memory model for the table path.
 * Assumes the unit latches the word in the cycle its read strobe stands. */
`timescale 1ns/1ps
module taxe_pmem_model
    import taxe_pkg::*;
(
    // Request in, word out
    input  wire taxe_prog_req_t req_i,
    output logic [15:0]         data_o
);
    logic [15:0] word;                                  // Word at the addressed location
    // ==========================================
    // Answer in the strobe cycle; inverse when idle so stale data never match
    assign word   = {req_i.addr[8:1] ^ 8'h3c, req_i.addr[8:1]};
    assign data_o = req_i.rd ? word : ~word;
endmodule

// file: verif/tb_top.sv
/* Self-checking bench of the execution unit.
 * Assumes the register map and opcodes of the package. */
`timescale 1ns/1ps
module tb_top
    import taxe_pkg::*;
;
    logic clk_i = 0, reset_i = 1, iv = 0, tw = 0, rw = 0, rr = 0, busy, skp;
    logic [15:0] ins = 0, pd;
    logic [7:0] fd = 0, hd;
    logic [2:0] ra = 0, hi = 0;
    logic [31:0] wd = 0, rd;
    taxe_prog_req_t pr;
    taxe_file_req_t fr;
    int n_fail = 0, n_tests = 0;
    taxe_exec i_dut (.clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(iv), .instr_i(ins), .two_word_i(tw),
        .busy_o(busy), .skip_o(skp), .prog_req_o(pr), .prog_data_i(pd), .file_req_o(fr), .file_data_i(fd),
        .hold_idx_i(hi), .hold_data_o(hd), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(rw),
        .reg_rd_i(rr), .reg_rdata_o(rd));
    taxe_pmem_model i_pmem (.req_i(pr), .data_o(pd));
    // ==========================================
    // Clock, watchdog and shared tasks
    initial forever #4 clk_i = ~clk_i;
    initial begin
        #100us;
        n_fail++;
        give_verdict();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_i);
        rw <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge clk_i);
        rw <= 1'b0;
    endtask
    task automatic rdv(input logic [2:0] a, output logic [31:0] v);
        @(posedge clk_i);
        rr <= 1'b1;
        ra <= a;
        @(posedge clk_i);
        rr <= 1'b0;
        #1 v = rd;
    endtask
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        logic [20:0] p, e, n;
        logic [7:0] k, f, x;
        logic [11:0] q, ib;
        logic [3:0] b;
        logic [1:0] m;
        logic [31:0] v;
        int s;
        void'($urandom(32'h6b8ded1d));
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        rdv(OFS_CTRL, v);
        chk(v, 32'h0);
        // Every pointer mode for read then write, at both pointer ends
        for (int i = 0; i < 24; i++) begin
            p = (i % 3 == 0) ? 21'h0 : (i % 3 == 1) ? 21'h1fffff : 21'($urandom);
            m = 2'(i / 3);
            k = 8'($urandom);
            wr(OFS_PTR, 32'(p));
            wr(OFS_LATCH, 32'(k));
            @(posedge clk_i);
            iv <= 1'b1;
            ins <= (i < 12) ? {OPC_TREAD, m} : {OPC_TWRITE, m};
            @(posedge clk_i);
            iv <= 1'b0;
            #1 chk(32'(busy), 32'h1);
            repeat (3) @(posedge clk_i);
            e = (m == MODE_PRE) ? p + 21'h1 : p;
            n = (m == MODE_KEEP) ? p : (m == MODE_PDEC) ? p - 21'h1 : p + 21'h1;
            rdv(OFS_PTR, v);
            chk(v, 32'(n));
            x = e[0] ? (e[8:1] ^ 8'h3c) : e[8:1];
            if (i < 12) begin
                rdv(OFS_LATCH, v);
                chk(v, 32'(x));
            end else begin
                @(posedge clk_i);
                hi <= e[2:0];
                @(posedge clk_i);
                #1 chk(32'(hd), 32'(k));
            end
        end
        $display("table test done");
        // Xor immediate, result and flags
        for (int i = 0; i < 8; i++) begin
            x = (i == 0) ? 8'h5a : 8'($urandom);
            k = (i == 0) ? 8'h5a : 8'($urandom);
            wr(OFS_ACC, 32'(x));
            @(posedge clk_i);
            iv <= 1'b1;
            ins <= {OPC_XORK, k};
            @(posedge clk_i);
            iv <= 1'b0;
            repeat (2) @(posedge clk_i);
            x = x ^ k;
            rdv(OFS_ACC, v);
            chk(v, 32'(x));
            rdv(OFS_STATUS, v);
            chk(v & 32'h7, {30'h0, x[7], x == 8'h0});
        end
        $display("xor test done");
        // Test and skip: bank mapping, indexed offsets, one and two word skips
        for (int i = 0; i < 8; i++) begin
            f = (i == 2 || i == 4) ? INDEX_LAST : (i == 6) ? ACCESS_SPLIT : 8'($urandom);
            k = (i % 3 == 0) ? 8'h0 : 8'($urandom) | 8'h1;
            b = 4'($urandom);
            ib = 12'($urandom);
            wr(OFS_CTRL, {24'h0, b, 3'h0, i[1]});
            wr(OFS_INDEX, {20'h0, ib});
            q = i[0] ? {b, f} : (i[1] && f <= INDEX_LAST) ? ib + 12'(f) : {(f >= ACCESS_SPLIT) ? BANK_HIGH : BANK_LOW, f};
            @(posedge clk_i);
            iv <= 1'b1;
            tw <= i[2];
            fd <= k;
            ins <= {OPC_TSTZ, i[0], f};
            @(posedge clk_i);
            ins <= 16'h0000;
            #1 chk(32'(fr.rd), 32'h1);
            s = 0;
            repeat (5) begin
                #1 if (skp === 1'b1) s++;
                if (fr.rd === 1'b1) chk(32'(fr.addr), 32'(q));
                @(posedge clk_i);
            end
            iv <= 1'b0;
            chk(s, (k == 8'h0) ? 1 + i[2] : 0);
        end
        $display("skip test done");
        give_verdict();
    end
endmodule
